// ==== watchdog_pkg.sv ====
package watchdog_pkg;

  // register location in data space
  localparam logic [7:0] WDOG_ADDR      = 8'hD8;
  localparam logic [7:0] WDOG_RESET_VAL = 8'hFE;
  localparam int         ACT_BIT        = 0;
  localparam int         SOFT_RESET_POS = 1;
  localparam int         PERIOD_LSB_POS = 7;
  localparam int         PERIOD_MSB_POS = 2;
  localparam int         COUNT_WIDTH    = 7;

  // prescaler: divide by 12 then by 256
  localparam int         PRESCALE_A     = 12;
  localparam int         PRESCALE_B     = 256;
  localparam int         TICK_CYCLES    = PRESCALE_A * PRESCALE_B;

  // reset pulse length held on the chip reset output
  localparam int         RESET_HOLD     = 4;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_access_type;

  typedef struct packed {
    logic stopReq;
    logic nmiLevel;
    logic wakeIrq;
    logic wakeNmi;
    logic globalIrqEnable;
  } power_ctrl_type;

endpackage

// ==== digital_watchdog_downcounter.sv ====
// Contract
// - counter decrements; bit 6 falling (0x40 to 0x3F) while armed resets the chip.
// - software option keeps watchdog off until activation bit written one.
// - once active only a chip reset deactivates it.
// - inactive watchdog lets STOP halt the oscillator.
// - hardware option without stop gate: always active, STOP acts as WAIT.
// - stop gate with NMI low: STOP acts as WAIT, counting continues.
// - stop gate with NMI high: STOP freezes counter, enters stop.
// - wake from stop resumes counting from held value.
// - reset value reads 0xFE.
// - writing soft-reset bit zero resets chip immediately.
// - period bits map reversed: bit 7 is LSB, bit 2 MSB.
// - 64 periods from 3072 to 196608 oscillator cycles.
// - hardware option forces activation bit to one.
// - inactive: plain 7-bit timer, soft-reset bit is MSB, no reset; the code still resets the chip on a write with that bit zero.
// - reset never earlier than first reload window after activation.
// - with interrupts disabled NMI does not wake from stop or wait.
// - watchdog reset restarts the device like an external reset.
// - while resetting internally the reset pin is driven low.
`timescale 1ns/1ps
module digital_watchdog_downcounter #(
  parameter bit HW_ACTIVATION = 1'b0,
  parameter bit EXT_STOP_CTRL = 1'b0
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // cpu data-space access
  input  wire watchdog_pkg::cpu_access_type cpuAccess,
  output logic [7:0]                       rdata,
  // power control
  input  wire watchdog_pkg::power_ctrl_type powerCtrl,
  output logic                             oscHalted,
  output logic                             inWait,
  output logic                             inStop,
  // reset outputs
  output logic                             chipResetReq,
  output logic                             resetPinOut,
  output logic                             resetPinOe
);

  typedef enum {RUN, WAIT_MODE, STOP_MODE} power_state_type;

  // reversing the register into the counter and back is its own inverse
  function automatic logic [5:0] reverse6(input logic [5:0] v);
    for (int i = 0; i < 6; i++)
    begin
      reverse6[i] = v[5 - i];
    end
  endfunction

  localparam int PRE_W = $clog2(watchdog_pkg::TICK_CYCLES);
  localparam int HOLD_W = $clog2(watchdog_pkg::RESET_HOLD + 1);

  logic [PRE_W-1:0]                      prescale;
  logic [PRE_W-1:0]                      next_prescale;
  logic [watchdog_pkg::COUNT_WIDTH-1:0]  count;
  logic [watchdog_pkg::COUNT_WIDTH-1:0]  next_count;
  logic                                  active;
  logic                                  next_active;
  power_state_type                       pstate;
  power_state_type                       next_pstate;
  logic [HOLD_W-1:0]                     hold;
  logic [HOLD_W-1:0]                     next_hold;

  logic wrHit;
  logic tick;
  logic frozen;
  logic expire;
  logic softReset;
  logic wake;
  logic [7:0] regView;

  assign wrHit = cpuAccess.write && (cpuAccess.addr == watchdog_pkg::WDOG_ADDR);
  assign frozen = (pstate == STOP_MODE);
  assign tick = !frozen && (prescale == PRE_W'(watchdog_pkg::TICK_CYCLES - 1));
  // expiry only when armed and the count actually runs out
  // bit 6 falling ends the period, so the six period bits give 1 to 64 ticks
  assign expire = active && tick && !wrHit && (count == 7'h40);
  assign softReset = wrHit && !cpuAccess.wdata[watchdog_pkg::SOFT_RESET_POS];
  assign wake = powerCtrl.globalIrqEnable && (powerCtrl.wakeIrq || powerCtrl.wakeNmi);

  // register image: period reversed into bits 7..2, count msb in bit 1
  assign regView = {reverse6(count[5:0]), count[6], active};

  always_comb
  begin
    next_prescale = frozen ? prescale : (tick ? '0 : prescale + 1'b1);
    next_count = count;
    next_active = active | HW_ACTIVATION;
    next_pstate = pstate;
    next_hold = (hold != '0) ? hold - 1'b1 : hold;
    if (wrHit)
    begin
      // load restarts the timeout, prescaler too
      next_count = {cpuAccess.wdata[watchdog_pkg::SOFT_RESET_POS],
                    reverse6(cpuAccess.wdata[7:2])};
      // a fresh load never expires before a full tick has passed
      next_prescale = '0;
      if (cpuAccess.wdata[watchdog_pkg::ACT_BIT])
      begin
        next_active = 1'b1;
      end
    end
    else if (tick)
    begin
      next_count = count - 1'b1;
    end
    case (pstate)
      RUN:
      begin
        if (powerCtrl.stopReq)
        begin
          if (!active)
          begin
            next_pstate = STOP_MODE;
          end
          else if (EXT_STOP_CTRL && powerCtrl.nmiLevel)
          begin
            next_pstate = STOP_MODE;
          end
          else
          begin
            next_pstate = WAIT_MODE;
          end
        end
      end
      WAIT_MODE, STOP_MODE:
      begin
        if (wake)
        begin
          next_pstate = RUN;
        end
      end
      default:
      begin
        next_pstate = RUN;
      end
    endcase
    if (expire || softReset)
    begin
      next_hold = HOLD_W'(watchdog_pkg::RESET_HOLD);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale <= '0;
      count <= 7'h7F;
      active <= 1'b0;
      pstate <= RUN;
      hold <= '0;
    end
    else
    begin
      prescale <= next_prescale;
      count <= next_count;
      active <= next_active;
      pstate <= next_pstate;
      hold <= next_hold;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= watchdog_pkg::WDOG_RESET_VAL;
    end
    else
    begin
      rdata <= {regView[7:1], regView[0] | HW_ACTIVATION};
    end
  end

  // the chip reset loops back into rst_n; held several cycles so it is seen
  assign chipResetReq = (hold != '0);
  assign resetPinOut = 1'b0;
  assign resetPinOe = !chipResetReq;
  assign oscHalted = (pstate == STOP_MODE);
  assign inStop = (pstate == STOP_MODE);
  assign inWait = (pstate == WAIT_MODE);

  property p_softreset;
    @(posedge ref_clk) disable iff (!rst_n)
      softReset |=> chipResetReq [*4];
  endproperty
  a_softreset: assert property (p_softreset) else $error("soft reset not held");

  property p_expire;
    @(posedge ref_clk) disable iff (!rst_n)
      (active && tick && !wrHit && count == 7'h40) |=> chipResetReq;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry gave no reset");

  property p_noreset_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      (!active && !softReset && hold == '0) |=> !chipResetReq;
  endproperty
  a_noreset_idle: assert property (p_noreset_idle) else $error("reset while inactive");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      active |=> active;
  endproperty
  a_sticky: assert property (p_sticky) else $error("watchdog deactivated");

  property p_arm;
    @(posedge ref_clk) disable iff (!rst_n)
      (wrHit && cpuAccess.wdata[0]) |=> active;
  endproperty
  a_arm: assert property (p_arm) else $error("activation write ignored");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
      wrHit |=> count == {$past(cpuAccess.wdata[1]), reverse6($past(cpuAccess.wdata[7:2]))};
  endproperty
  a_load: assert property (p_load) else $error("write did not load counter");

  property p_freeze;
    @(posedge ref_clk) disable iff (!rst_n)
      (frozen && !wrHit) |=> $stable(count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved in stop");

  property p_wait;
    @(posedge ref_clk) disable iff (!rst_n)
      (pstate == RUN && powerCtrl.stopReq && active && !(EXT_STOP_CTRL && powerCtrl.nmiLevel))
      |=> inWait && !oscHalted;
  endproperty
  a_wait: assert property (p_wait) else $error("stop not taken as wait");

  property p_nowake;
    @(posedge ref_clk) disable iff (!rst_n)
      (pstate != RUN && !powerCtrl.globalIrqEnable) |=> pstate != RUN;
  endproperty
  a_nowake: assert property (p_nowake) else $error("woke with interrupts off");

  property p_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      chipResetReq |-> !resetPinOe && !resetPinOut;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin not driven low");

  property p_pin_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !chipResetReq |-> resetPinOe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("reset pin driven while idle");

  property p_stop_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (pstate == RUN && powerCtrl.stopReq && !active) |=> inStop && oscHalted;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop not entered while inactive");

  property p_stop_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (pstate == RUN && powerCtrl.stopReq && active && EXT_STOP_CTRL && powerCtrl.nmiLevel)
      |=> inStop;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("gated stop not entered");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (pstate != RUN && wake) |=> pstate == RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled wake ignored");

  property p_tick;
    @(posedge ref_clk) disable iff (!rst_n)
      (tick && !wrHit) |=> count == $past(count) - 7'h01;
  endproperty
  a_tick: assert property (p_tick) else $error("tick did not decrement");

  property p_hw_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      HW_ACTIVATION |=> rdata[0];
  endproperty
  a_hw_bit: assert property (p_hw_bit) else $error("activation bit not forced");

  property p_hw_active;
    @(posedge ref_clk) disable iff (!rst_n)
      HW_ACTIVATION |=> active;
  endproperty
  a_hw_active: assert property (p_hw_active) else $error("hardware option not active");

  property p_noreset_run;
    @(posedge ref_clk) disable iff (!rst_n)
      (!expire && !softReset && hold == '0) |=> !chipResetReq;
  endproperty
  a_noreset_run: assert property (p_noreset_run) else $error("reset without cause");

  property p_reload_prescale;
    @(posedge ref_clk) disable iff (!rst_n)
      wrHit |=> prescale == '0;
  endproperty
  a_reload_prescale: assert property (p_reload_prescale) else $error("load kept prescaler");

  property p_soft_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      softReset |=> !resetPinOe;
  endproperty
  a_soft_pin: assert property (p_soft_pin) else $error("soft reset left pin free");

endmodule

// ==== tb_digital_watchdog_downcounter.sv ====
`timescale 1ns/1ps
module tb_digital_watchdog_downcounter;
  logic                         ref_clk = 1'b0;
  logic                         rst_n = 1'b0;
  watchdog_pkg::cpu_access_type cpuAccess = '0;
  watchdog_pkg::power_ctrl_type powerCtrl = '0;
  logic [7:0]                   rdata;
  logic                         oscHalted;
  logic                         inWait;
  logic                         inStop;
  logic                         chipResetReq;
  logic                         resetPinOut;
  logic                         resetPinOe;
  int                           errTotal = 0;
  int                           nChecks = 0;
  int                           i;

  always #12.5 ref_clk = ~ref_clk;

  digital_watchdog_downcounter dut_u (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .cpuAccess    (cpuAccess),
    .rdata        (rdata),
    .powerCtrl    (powerCtrl),
    .oscHalted    (oscHalted),
    .inWait       (inWait),
    .inStop       (inStop),
    .chipResetReq (chipResetReq),
    .resetPinOut  (resetPinOut),
    .resetPinOe   (resetPinOe)
  );

  // settle past the edge before sampling
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpuAccess <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    cpuAccess.write <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic test_reset();
    tk(1);
    chk("rdata", watchdog_pkg::WDOG_RESET_VAL, rdata);
    chk("chipResetReq", 8'h00, {7'h00, chipResetReq});
    chk("resetPinOe", 8'h01, {7'h00, resetPinOe});
  endtask

  // count 0x41 is written as 0x82 because of the reversed period bits
  task automatic test_load();
    wr(watchdog_pkg::WDOG_ADDR, 8'h82);
    tk(2);
    chk("rdata", 8'h82, rdata);
    wr(8'hD9, 8'h00);
    tk(2);
    chk("rdata", 8'h82, rdata);
    chk("chipResetReq", 8'h00, {7'h00, chipResetReq});
  endtask

  // inactive timer: one tick takes 0x41 to 0x40, MSB kept, no reset
  task automatic test_timer();
    wr(watchdog_pkg::WDOG_ADDR, 8'h82);
    for (i = 0; i < 3000; i++)
    begin
      tk(1);
      if (chipResetReq !== 1'b0)
        chk("noReset", 8'h00, 8'h01);
    end
    chk("rdata", 8'h82, rdata);
    tk(watchdog_pkg::TICK_CYCLES - 3000 + 4);
    chk("rdata", 8'h02, rdata);
  endtask

  task automatic test_stop();
    @(posedge ref_clk);
    powerCtrl.stopReq <= 1'b1;
    @(posedge ref_clk);
    powerCtrl.stopReq <= 1'b0;
    powerCtrl.wakeNmi <= 1'b1;
    tk(1);
    chk("inStop", 8'h01, {7'h00, inStop});
    chk("oscHalted", 8'h01, {7'h00, oscHalted});
    tk(4);
    chk("inStop", 8'h01, {7'h00, inStop});
    @(posedge ref_clk);
    powerCtrl.globalIrqEnable <= 1'b1;
    for (i = 0; i < 4 && inStop !== 1'b0; i++)
      tk(1);
    chk("inStop", 8'h00, {7'h00, inStop});
    powerCtrl.wakeNmi <= 1'b0;
  endtask

  task automatic test_activate();
    chk("rdata", 8'h00, {7'h00, rdata[0]});
    wr(watchdog_pkg::WDOG_ADDR, 8'h83);
    tk(2);
    chk("rdata", 8'h83, rdata);
    wr(watchdog_pkg::WDOG_ADDR, 8'h82);
    tk(2);
    chk("rdata", 8'h83, rdata);
    @(posedge ref_clk);
    powerCtrl.stopReq <= 1'b1;
    @(posedge ref_clk);
    powerCtrl.stopReq <= 1'b0;
    tk(1);
    chk("inWait", 8'h01, {7'h00, inWait});
    chk("oscHalted", 8'h00, {7'h00, oscHalted});
    powerCtrl.wakeIrq <= 1'b1;
    tk(2);
    chk("inWait", 8'h00, {7'h00, inWait});
    powerCtrl.wakeIrq <= 1'b0;
  endtask

  // armed with count 0x40: a single tick drops bit 6
  task automatic test_expire();
    int n;
    wr(watchdog_pkg::WDOG_ADDR, 8'h03);
    for (n = 0; n < 3100 && chipResetReq !== 1'b1; n++)
      tk(1);
    nChecks++;
    if (n != watchdog_pkg::TICK_CYCLES)
    begin
      errTotal++;
      $display("BAD expiryCycles expected %0d seen %0d", watchdog_pkg::TICK_CYCLES, n);
    end
    chk("resetPinOe", 8'h00, {7'h00, resetPinOe});
    tk(6);
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    tk(2);
    chk("rdata", watchdog_pkg::WDOG_RESET_VAL, rdata);
  endtask

  // soft reset pulse, then the chip reset it asks for
  task automatic test_soft_reset();
    wr(watchdog_pkg::WDOG_ADDR, 8'hFD);
    for (i = 0; i < 4 && chipResetReq !== 1'b1; i++)
      tk(1);
    chk("resetPinOe", 8'h00, {7'h00, resetPinOe});
    for (i = 0; i < 8 && chipResetReq === 1'b1; i++)
      tk(1);
    chk("holdCycles", 8'(watchdog_pkg::RESET_HOLD), 8'(i + 1));
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    tk(2);
    chk("rdata", watchdog_pkg::WDOG_RESET_VAL, rdata);
  endtask

  initial
  begin
    tk(4);
    rst_n <= 1'b1;
    test_reset();
    test_load();
    test_timer();
    test_stop();
    test_activate();
    test_expire();
    test_soft_reset();
    conclude();
  end
endmodule
